/* inc/column_rx_map.vh */
// Constants for the accumulator column receiver: commands, timing, sizes.
// Assumes a 50 MHz system clock; include once per design file.
`ifndef COLUMN_RX_MAP_VH
`define COLUMN_RX_MAP_VH

// ********************************************************
// Clock and timing
// ********************************************************
`define CLOCK_PERIOD_NS 20
`define RESP_TIMEOUT_NS 2000
`define RESP_TIMEOUT_CYC (`RESP_TIMEOUT_NS / `CLOCK_PERIOD_NS)
`define FRAME_TIMEOUT_NS 4000
`define FRAME_TIMEOUT_CYC (`FRAME_TIMEOUT_NS / `CLOCK_PERIOD_NS)
`define SETTLE_CYC 4'h2

// ********************************************************
// Column geometry
// ********************************************************
`define NUM_COLUMNS 8
`define ROWS_PER_COLUMN 8

// ********************************************************
// Serial command words, sent after a one start bit, MSB first
// ********************************************************
`define CMD_POLL 8'h01
`define CMD_TX_REQ 8'h02
`define CMD_BITS 4'h9

// ********************************************************
// Scheduler states
// ********************************************************
`define ST_IDLE 3'h0
`define ST_POLL 3'h1
`define ST_RESP 3'h2
`define ST_REQ 3'h3
`define ST_WFRM 3'h4
`define ST_INFRM 3'h5
`define ST_NEXT 3'h6
`define ST_SETTLE 3'h7

`endif

/* rtl/byte_fifo.v */
// Small synchronous FIFO with a registered output word.
// Assumes both sides on the same clock; storage in flip-flops.
`timescale 1ns/1ps

module byte_fifo #(
	parameter WIDTH = 9,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	// Clock and reset
	input wire clock,
	input wire rst_n,
	// Fill side
	input wire in_valid,
	input wire [WIDTH-1:0] in_data,
	output wire in_ready,
	// Drain side
	output reg out_valid,
	output reg [WIDTH-1:0] out_data,
	input wire out_ready
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_reg;
	reg [AW-1:0] rd_ptr_reg;
	reg [AW:0] count_reg;
	wire push;
	wire pop;

	assign in_ready = (count_reg != DEPTH[AW:0]);
	assign push = in_valid && in_ready;
	// The output register refills only when empty or being taken
	assign pop = (count_reg != {(AW+1){1'b0}}) && (!out_valid || out_ready);

	always @(posedge clock) begin
		if (push)
			mem[wr_ptr_reg] <= in_data;
	end

	always @(posedge clock) begin
		if (!rst_n) begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
			out_valid <= 1'b0;
			out_data <= {WIDTH{1'b0}};
		end else begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
				out_data <= mem[rd_ptr_reg];
				out_valid <= 1'b1;
			end else if (out_ready) begin
				out_valid <= 1'b0;
			end
			if (push && !pop)
				count_reg <= count_reg + 1'b1;
			else if (pop && !push)
				count_reg <= count_reg - 1'b1;
		end
	end

endmodule

/* rtl/column_capture.v */
// Dual-edge capture of one column's byte lane into two frame buffers.
// Assumes lane pins are asynchronous; last byte is the 8-bit sum of the rest.
`timescale 1ns/1ps

module column_capture #(
	parameter BUF_DEPTH = 64,
	parameter BW = 6
) (
	// Clock and reset
	input wire clock,
	input wire rst_n,
	// Column pins
	input wire [7:0] lane_pin,
	input wire valid_n_pin,
	// Control
	input wire forward_en,
	// Status toward scheduler
	output wire frame_active,
	output reg done_pulse,
	output reg both_bad_pulse,
	// Write side of the output FIFO
	output reg wr_valid,
	output reg [8:0] wr_data,
	input wire wr_ready
);

`include "column_rx_map.vh"

	function sum_ok;
		input [7:0] sum;
		input [7:0] last;
		input [BW:0] cnt;
		input ovf;
		begin
			sum_ok = (cnt > 1) && !ovf && (sum == last);
		end
	endfunction

	// ********************************************************
	// Pin synchronisers, one per sampling edge
	// ********************************************************
	reg [8:0] rise_s1_reg;
	reg [8:0] rise_s2_reg;
	reg [8:0] fall_s1_reg;
	reg [8:0] fall_s2_reg;
	reg [8:0] fall_rt_reg;

	always @(posedge clock) begin
		rise_s1_reg <= {valid_n_pin, lane_pin};
		rise_s2_reg <= rise_s1_reg;
		fall_rt_reg <= fall_s2_reg;
	end

	// Falling-edge copy, retimed so the rest sees one clock edge
	always @(negedge clock) begin
		fall_s1_reg <= {valid_n_pin, lane_pin};
		fall_s2_reg <= fall_s1_reg;
	end

	assign frame_active = !rise_s2_reg[8];

	// ********************************************************
	// Two frame buffers with running checksums
	// ********************************************************
	reg [7:0] rise_mem [0:BUF_DEPTH-1];
	reg [7:0] fall_mem [0:BUF_DEPTH-1];
	reg [BW:0] rcnt_reg;
	reg [BW:0] fcnt_reg;
	reg [7:0] rsum_reg;
	reg [7:0] fsum_reg;
	reg [7:0] rlast_reg;
	reg [7:0] flast_reg;
	reg rovf_reg;
	reg fovf_reg;
	reg rprev_reg;
	reg [1:0] st_reg;
	reg [BW:0] idx_reg;
	reg use_fall_reg;
	reg keep_reg;
	wire rok;
	wire fok;
	wire [7:0] rd_byte;

	assign rok = sum_ok(rsum_reg, rlast_reg, rcnt_reg, rovf_reg);
	assign fok = sum_ok(fsum_reg, flast_reg, fcnt_reg, fovf_reg);
	assign rd_byte = use_fall_reg ? fall_mem[idx_reg[BW-1:0]] :
		rise_mem[idx_reg[BW-1:0]];

	always @(posedge clock) begin
		if (!rise_s2_reg[8] && st_reg == 2'h0 && !rcnt_reg[BW])
			rise_mem[rcnt_reg[BW-1:0]] <= rise_s2_reg[7:0];
		if (!fall_rt_reg[8] && st_reg == 2'h0 && !fcnt_reg[BW])
			fall_mem[fcnt_reg[BW-1:0]] <= fall_rt_reg[7:0];
	end

	always @(posedge clock) begin
		if (!rst_n) begin
			rcnt_reg <= {(BW+1){1'b0}};
			fcnt_reg <= {(BW+1){1'b0}};
			rsum_reg <= 8'h00;
			fsum_reg <= 8'h00;
			rlast_reg <= 8'h00;
			flast_reg <= 8'h00;
			rovf_reg <= 1'b0;
			fovf_reg <= 1'b0;
			rprev_reg <= 1'b1;
			st_reg <= 2'h0;
			idx_reg <= {(BW+1){1'b0}};
			use_fall_reg <= 1'b0;
			keep_reg <= 1'b0;
			done_pulse <= 1'b0;
			both_bad_pulse <= 1'b0;
			wr_valid <= 1'b0;
			wr_data <= 9'h000;
		end else begin
			done_pulse <= 1'b0;
			both_bad_pulse <= 1'b0;
			rprev_reg <= rise_s2_reg[8];
			case (st_reg)
			2'h0: begin
				if (!rise_s2_reg[8]) begin
					if (rcnt_reg[BW])
						rovf_reg <= 1'b1;
					else
						rcnt_reg <= rcnt_reg + 1'b1;
					if (rcnt_reg != 0)
						rsum_reg <= rsum_reg + rlast_reg;
					rlast_reg <= rise_s2_reg[7:0];
				end
				if (!fall_rt_reg[8]) begin
					if (fcnt_reg[BW])
						fovf_reg <= 1'b1;
					else
						fcnt_reg <= fcnt_reg + 1'b1;
					if (fcnt_reg != 0)
						fsum_reg <= fsum_reg + flast_reg;
					flast_reg <= fall_rt_reg[7:0];
				end
				// Rising edge of the frame signal ends the frame
				if (rise_s2_reg[8] && !rprev_reg)
					st_reg <= 2'h1;
			end
			2'h1: begin
				// Falling copy lags by half a cycle; it is complete now
				use_fall_reg <= !rok;
				keep_reg <= (rok || fok) && forward_en;
				both_bad_pulse <= !rok && !fok;
				idx_reg <= {(BW+1){1'b0}};
				st_reg <= 2'h2;
			end
			2'h2: begin
				if (!keep_reg || idx_reg == (use_fall_reg ? fcnt_reg : rcnt_reg))
					begin
					if (!wr_valid || wr_ready) begin
						wr_valid <= 1'b0;
						st_reg <= 2'h3;
					end
				end else if (!wr_valid || wr_ready) begin
					wr_valid <= 1'b1;
					wr_data <= {idx_reg + 1'b1 ==
						(use_fall_reg ? fcnt_reg : rcnt_reg), rd_byte};
					idx_reg <= idx_reg + 1'b1;
				end
			end
			default: begin
				rcnt_reg <= {(BW+1){1'b0}};
				fcnt_reg <= {(BW+1){1'b0}};
				rsum_reg <= 8'h00;
				fsum_reg <= 8'h00;
				rovf_reg <= 1'b0;
				fovf_reg <= 1'b0;
				done_pulse <= 1'b1;
				st_reg <= 2'h0;
			end
			endcase
		end
	end

endmodule

/* rtl/column_receiver.v */
// Operation
// - Eight columns of eight controllers, each column handled on its own.
// - Active-low selects, at most one asserted per column.
// - Select index is row times eight plus column.
// - One serial command line per column; only selected controller answers.
// - Lane bytes are frame data only while the frame signal is low.
// - Transmit request is sent before any frame data is expected.
// - Lane and frame signal inputs are sampled on both clock edges; response lines on the rising edge only.
// - Rising and falling samples go to separate frame buffers.
// - Only the copy with a good checksum is forwarded.
// - Per column, round-robin polling and download when data is ready.
// - Clock divided by four drives one clock to each column.
// - Column clocks come from a flop on the system clock edge.
// - Returned command lines are ignored.
// - Keep unloading one controller until it reports empty.
// - Status flag only when both copies fail the checksum.
// - Global acquire enable and a discard mode.
//
// Top of the column receiver: scheduler, command serialiser, clock divider.
// Assumes column pins are asynchronous and control inputs are synchronous.
`timescale 1ns/1ps
`include "column_rx_map.vh"

module column_receiver #(
	parameter BUF_DEPTH = 64,
	parameter BW = 6,
	parameter FIFO_DEPTH = 8,
	parameter RESP_TIMEOUT = `RESP_TIMEOUT_CYC,
	parameter FRAME_TIMEOUT = `FRAME_TIMEOUT_CYC
) (
	// Clock and reset
	input wire clock,
	input wire rst_n,
	// Control from the surrounding chip
	input wire acquire_enable,
	input wire discard_mode,
	// Column pins
	output wire [63:0] controller_select_n,
	output wire [7:0] column_command_line,
	output wire [7:0] column_clock_out,
	input wire [7:0] column_response_line,
	input wire [63:0] column_byte_lane,
	input wire [7:0] column_valid_n,
	input wire [7:0] command_return_line,
	// Frame streams toward the frame builder
	output wire [63:0] frame_data,
	output wire [7:0] frame_last,
	output wire [7:0] frame_valid,
	input wire [7:0] frame_ready,
	// Status
	output reg [7:0] checksum_error
);

	// Row seven wraps back to row zero
	function [2:0] next_row;
		input [2:0] row;
		begin
			next_row = row + 3'h1;
		end
	endfunction

	// ********************************************************
	// Column clock divider
	// ********************************************************
	reg [1:0] div_reg;
	reg col_clk_reg;

	always @(posedge clock) begin
		if (!rst_n) begin
			div_reg <= 2'h0;
			col_clk_reg <= 1'b0;
		end else begin
			div_reg <= div_reg + 2'h1;
			if (div_reg[0])
				col_clk_reg <= !col_clk_reg;
		end
	end

	assign column_clock_out = {8{col_clk_reg}};

	wire [7:0] unused_return;
	assign unused_return = command_return_line;

	// ********************************************************
	// Response line synchronisers
	// ********************************************************
	reg [7:0] resp_s1_reg;
	reg [7:0] resp_s2_reg;

	always @(posedge clock) begin
		resp_s1_reg <= column_response_line;
		resp_s2_reg <= resp_s1_reg;
	end

	wire [7:0] err_next;

	// ********************************************************
	// One scheduler per column
	// ********************************************************
	genvar c;
	genvar r;
	generate
	for (c = 0; c < 8; c = c + 1) begin : col
		reg [2:0] st_reg;
		reg [2:0] row_reg;
		reg sel_on_reg;
		reg [7:0] sel_n_reg;
		reg [8:0] shift_reg;
		reg [3:0] bits_reg;
		reg cmd_reg;
		reg resp_start_reg;
		reg [15:0] timer_reg;
		reg [3:0] settle_reg;
		wire frame_active;
		wire done_pulse;
		wire both_bad;
		wire wr_valid;
		wire [8:0] wr_data;
		wire wr_ready;
		wire [8:0] out_word;

		for (r = 0; r < 8; r = r + 1) begin : sel
			assign controller_select_n[r*8+c] = sel_n_reg[r];
		end
		assign column_command_line[c] = cmd_reg;
		assign frame_data[c*8+7:c*8] = out_word[7:0];
		assign frame_last[c] = out_word[8];

		always @(posedge clock) begin
			if (!rst_n) begin
				st_reg <= `ST_IDLE;
				row_reg <= 3'h0;
				sel_on_reg <= 1'b0;
				sel_n_reg <= 8'hff;
				shift_reg <= 9'h000;
				bits_reg <= 4'h0;
				cmd_reg <= 1'b0;
				resp_start_reg <= 1'b0;
				timer_reg <= 16'h0000;
				settle_reg <= 4'h0;
			end else begin
				sel_n_reg <= sel_on_reg ? ~(8'h01 << row_reg) : 8'hff;
				// one bit per cycle, start bit first
				if (bits_reg != 4'h0) begin
					cmd_reg <= shift_reg[8];
					shift_reg <= {shift_reg[7:0], 1'b0};
					bits_reg <= bits_reg - 4'h1;
				end else begin
					cmd_reg <= 1'b0;
				end
				case (st_reg)
				`ST_IDLE: begin
					if (acquire_enable) begin
						sel_on_reg <= 1'b1;
						settle_reg <= `SETTLE_CYC;
						st_reg <= `ST_SETTLE;
					end
				end
				`ST_SETTLE: begin
					if (settle_reg != 4'h0) begin
						settle_reg <= settle_reg - 4'h1;
					end else begin
						st_reg <= `ST_POLL;
					end
				end
				`ST_POLL: begin
					shift_reg <= {1'b1, `CMD_POLL};
					bits_reg <= `CMD_BITS;
					resp_start_reg <= 1'b0;
					timer_reg <= 16'h0000;
					st_reg <= `ST_RESP;
				end
				`ST_RESP: begin
					// single responder, start bit then ready bit
					timer_reg <= timer_reg + 16'h0001;
					if (resp_start_reg) begin
						if (resp_s2_reg[c]) begin
							st_reg <= `ST_REQ;
						end else begin
							st_reg <= `ST_NEXT;
						end
					end else if (bits_reg == 4'h0 && resp_s2_reg[c]) begin
						resp_start_reg <= 1'b1;
					end else if (timer_reg == RESP_TIMEOUT[15:0]) begin
						st_reg <= `ST_NEXT;
					end
				end
				`ST_REQ: begin
					if (bits_reg == 4'h0) begin
						shift_reg <= {1'b1, `CMD_TX_REQ};
						bits_reg <= `CMD_BITS;
						timer_reg <= 16'h0000;
						st_reg <= `ST_WFRM;
					end
				end
				`ST_WFRM: begin
					// frame signal low opens the frame
					timer_reg <= timer_reg + 16'h0001;
					if (frame_active) begin
						st_reg <= `ST_INFRM;
					end else if (timer_reg == FRAME_TIMEOUT[15:0]) begin
						st_reg <= `ST_NEXT;
					end
				end
				`ST_INFRM: begin
					// capture finishes after frame signal rises
					// poll the same controller until empty
					if (done_pulse) begin
						st_reg <= `ST_POLL;
					end
				end
				`ST_NEXT: begin
					// hold select while a frame is in progress
					if (!frame_active && bits_reg == 4'h0) begin
						row_reg <= next_row(row_reg);
						sel_on_reg <= 1'b0;
						st_reg <= `ST_IDLE;
					end
				end
				default: begin
					st_reg <= `ST_IDLE;
				end
				endcase
			end
		end

		column_capture #(
			.BUF_DEPTH(BUF_DEPTH),
			.BW(BW)
		) capture (
			.clock(clock),
			.rst_n(rst_n),
			.lane_pin(column_byte_lane[c*8+7:c*8]),
			.valid_n_pin(column_valid_n[c]),
			.forward_en(!discard_mode),
			.frame_active(frame_active),
			.done_pulse(done_pulse),
			.both_bad_pulse(both_bad),
			.wr_valid(wr_valid),
			.wr_data(wr_data),
			.wr_ready(wr_ready)
		);

		// A full FIFO stalls the readout and so the next poll
		byte_fifo #(
			.WIDTH(9),
			.DEPTH(FIFO_DEPTH),
			.AW(3)
		) fifo (
			.clock(clock),
			.rst_n(rst_n),
			.in_valid(wr_valid),
			.in_data(wr_data),
			.in_ready(wr_ready),
			.out_valid(frame_valid[c]),
			.out_data(out_word),
			.out_ready(frame_ready[c])
		);

		assign err_next[c] = both_bad;
	end
	endgenerate

	// ********************************************************
	// Status
	// ********************************************************
	// flag only when both copies failed
	always @(posedge clock) begin
		if (!rst_n)
			checksum_error <= 8'h00;
		else
			checksum_error <= err_next;
	end

endmodule

/* verification/column_receiver_checker.sv */
// Assertions on the column receiver top ports, column 0 and shared pins.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ps

module column_receiver_checker (
	// Clock and reset
	input wire clock,
	input wire rst_n,
	// Control and column pins
	input wire discard_mode,
	input wire [63:0] controller_select_n,
	input wire [7:0] column_command_line,
	input wire [7:0] column_clock_out,
	input wire [7:0] column_valid_n,
	// Frame stream and status
	input wire [63:0] frame_data,
	input wire [7:0] frame_last,
	input wire [7:0] frame_valid,
	input wire [7:0] frame_ready,
	input wire [7:0] checksum_error
);
	reg [3:0] pos_reg;
	reg sel_ok;
	wire [7:0] col0_sel;
	integer c, r, n;

	genvar g;
	for (g = 0; g < 8; g = g + 1)
		assign col0_sel[g] = controller_select_n[g * 8];

	always @* begin
		sel_ok = 1'b1;
		for (c = 0; c < 8; c = c + 1) begin
			n = 0;
			for (r = 0; r < 8; r = r + 1)
				n = n + !controller_select_n[r * 8 + c];
			if (n > 1)
				sel_ok = 1'b0;
		end
	end

	// Bit slot within a command word; slots 1 to 6 are zero in every word
	always @(posedge clock) begin
		if (!rst_n)
			pos_reg <= 4'h0;
		else if (pos_reg != 4'h0)
			pos_reg <= (pos_reg == 4'h8) ? 4'h0 : pos_reg + 4'h1;
		else if (column_command_line[0])
			pos_reg <= 4'h1;
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	sequence frame_busy;
		(!column_valid_n[0])[*3];
	endsequence
	sequence clk_quarter;
		##2 $fell(column_clock_out[0]) ##2 $rose(column_clock_out[0]);
	endsequence

	a_one_select: assert property (sel_ok)
		else $error("two selects low in one column");
	a_word_zero_bits: assert property
		(pos_reg >= 4'h1 && pos_reg <= 4'h6 |-> !column_command_line[0])
		else $error("command word bit not zero");
	a_cmd_when_sel: assert property
		($rose(column_command_line[0]) |-> col0_sel != 8'hff)
		else $error("command sent with no select");
	a_hold_in_frame: assert property (frame_busy |-> $stable(col0_sel))
		else $error("select moved during frame");
	a_clock_quarter: assert property
		($rose(column_clock_out[0]) |-> clk_quarter)
		else $error("column clock not divide by four");
	a_clocks_same: assert property
		(column_clock_out == {8{column_clock_out[0]}})
		else $error("column clocks differ");
	a_error_pulse: assert property
		(checksum_error[0] |=> !checksum_error[0])
		else $error("checksum flag longer than one cycle");
	a_discard_quiet: assert property
		((discard_mode && !frame_valid[0])[*8] |=> !frame_valid[0])
		else $error("frame output in discard mode");
	a_stream_hold: assert property
		(frame_valid[0] && !frame_ready[0] |=> frame_valid[0] &&
			$stable(frame_data[7:0]) && $stable(frame_last[0]))
		else $error("stream word dropped while stalled");
	a_release_gap: assert property
		(col0_sel != 8'hff && $past(col0_sel) != 8'hff |->
			$stable(col0_sel))
		else $error("select moved to a new row with no gap");
endmodule

bind column_receiver column_receiver_checker CHK (.clock(clock),
	.rst_n(rst_n), .discard_mode(discard_mode),
	.controller_select_n(controller_select_n),
	.column_command_line(column_command_line),
	.column_clock_out(column_clock_out), .column_valid_n(column_valid_n),
	.frame_data(frame_data), .frame_last(frame_last),
	.frame_valid(frame_valid), .frame_ready(frame_ready),
	.checksum_error(checksum_error));

/* verification/column_partner.sv */
// Behavioural column of controllers: answers polls, sends frames.
// Assumes the receiver's command framing and trailing sum byte.
`timescale 1ns/1ps
`include "column_rx_map.vh"

module column_partner (
	// Clock
	input wire clock,
	// Column pins
	input wire [7:0] sel_n,
	input wire cmd,
	output reg resp,
	output reg [7:0] lane,
	output reg valid_n
);
	reg [7:0] word;
	reg bad = 1'b0;
	integer nb = 0;
	integer frames_left = 0;
	integer row_seen = 0;
	integer prev_row = 0;

	initial begin
		resp = 1'b0;
		lane = 8'h00;
		valid_n = 1'b1;
	end

	task serve;
		reg [7:0] sum;
		integer i;
		begin
			if (word == `CMD_POLL) begin
				@(posedge clock) #1 resp = 1'b1;
				@(posedge clock) #1 resp = (frames_left > 0);
				@(posedge clock) #1 resp = 1'b0;
			end
			// data only after a transmit request
			if (word == `CMD_TX_REQ && frames_left > 0) begin
				prev_row = row_seen;
				for (i = 0; i < 8; i = i + 1)
					if (!sel_n[i])
						row_seen = i;
				sum = 8'h00;
				@(posedge clock) #1 valid_n = 1'b0;
				// address bytes lead, sum byte last
				for (i = 0; i < 11; i = i + 1) begin
					lane = 8'h10 + i;
					sum = sum + lane;
					@(posedge clock) #1;
				end
				lane = bad ? ~sum : sum;
				@(posedge clock) #1;
				// frame signal high ends the frame
				valid_n = 1'b1;
				lane = ~lane;
				frames_left = frames_left - 1;
			end
		end
	endtask

	// only a selected controller listens and answers
	always @(posedge clock) begin
		if (nb > 0) begin
			word = {word[6:0], cmd};
			nb = nb - 1;
			if (nb == 0)
				serve();
		end else if (cmd && sel_n != 8'hff)
			nb = 8;
	end
endmodule

/* verification/accumulator_column_receiver_tb.sv */
// Bench for the column receiver: column 0 faces a controller model.
// Assumes the hand-over timing; other columns see idle controllers.
`timescale 1ns/1ps

module accumulator_column_receiver_tb;
	reg clock;
	reg rst_n;
	reg acquire_enable;
	reg discard_mode;
	reg [7:0] frame_ready;
	reg far_seen = 1'b0;
	reg [1:0] s;
	wire [63:0] controller_select_n;
	wire [7:0] column_command_line;
	wire [7:0] column_clock_out;
	wire [63:0] frame_data;
	wire [7:0] frame_last;
	wire [7:0] frame_valid;
	wire [7:0] checksum_error;
	wire [7:0] col0_sel;
	wire resp0;
	wire [7:0] lane0;
	wire vn0;
	integer err_total = 0;
	integer compares = 0;

	genvar r;
	for (r = 0; r < 8; r = r + 1)
		assign col0_sel[r] = controller_select_n[r * 8];

	// Short timeouts keep idle columns rotating quickly
	column_receiver #(.RESP_TIMEOUT(20), .FRAME_TIMEOUT(40)) DUT (
		.clock(clock), .rst_n(rst_n), .acquire_enable(acquire_enable),
		.discard_mode(discard_mode),
		.controller_select_n(controller_select_n),
		.column_command_line(column_command_line),
		.column_clock_out(column_clock_out),
		.column_response_line({7'h00, resp0}),
		.column_byte_lane({56'h0, lane0}), .column_valid_n({7'h7f, vn0}),
		.command_return_line(~column_command_line),
		.frame_data(frame_data), .frame_last(frame_last),
		.frame_valid(frame_valid), .frame_ready(frame_ready),
		.checksum_error(checksum_error));

	column_partner PART (.clock(clock), .sel_n(col0_sel),
		.cmd(column_command_line[0]), .resp(resp0), .lane(lane0),
		.valid_n(vn0));

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	always @(negedge clock)
		if (controller_select_n[63] === 1'b0)
			far_seen <= 1'b1;

	task check(input [63:0] got, input [63:0] exp);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				err_total = err_total + 1;
				$display("[FAIL] %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask

	task test_done;
		begin
			$display("compares %0d mismatches %0d", compares, err_total);
			if (err_total == 0 && compares > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask

	task wait_sel(input [7:0] want);
		integer n;
		begin
			for (n = 0; n < 3000 && col0_sel !== want; n = n + 1)
				@(negedge clock);
			check(col0_sel, want);
		end
	endtask

	task observe(output [1:0] seen);
		integer n;
		begin
			seen = 2'b00;
			for (n = 0; n < 600; n = n + 1) begin
				@(negedge clock);
				seen = seen | {checksum_error[0] === 1'b1, frame_valid[0] === 1'b1};
			end
		end
	endtask

	task recv_frame;
		reg [7:0] sum;
		reg [7:0] b;
		integer i;
		integer n;
		begin
			sum = 8'h00;
			for (i = 0; i < 12; i = i + 1) begin
				b = (i == 11) ? sum : 8'h10 + i;
				sum = sum + b;
				for (n = 0; n < 500 && frame_valid[0] !== 1'b1; n = n + 1)
					@(negedge clock);
				check({frame_last[0], frame_data[7:0]}, {i == 11, b});
				@(negedge clock);
			end
		end
	endtask

	task t_scan;
		begin
			// Rows of column 0 visited in order with a gap between
			wait_sel(8'hfe);
			wait_sel(8'hff);
			wait_sel(8'hfd);
			wait_sel(8'hff);
			wait_sel(8'hfb);
			$display("t_scan done");
		end
	endtask

	task t_frames;
		integer n;
		begin
			PART.frames_left = 2;
			for (n = 0; n < 2000 && frame_valid[0] !== 1'b1; n = n + 1)
				@(negedge clock);
			// Sink stalls so the output buffer fills and refuses
			repeat (40) @(negedge clock);
			check(frame_valid[0], 1'b1);
			// Sink stays ready across both frames
			frame_ready = 8'h01;
			recv_frame;
			recv_frame;
			frame_ready = 8'h00;
			check(PART.row_seen, PART.prev_row);
			$display("t_frames done");
		end
	endtask

	task t_bad;
		begin
			PART.bad = 1'b1;
			PART.frames_left = 1;
			observe(s);
			PART.bad = 1'b0;
			check(s, 2'b10);
			check(PART.frames_left, 0);
			$display("t_bad done");
		end
	endtask

	task t_discard;
		begin
			discard_mode = 1'b1;
			PART.frames_left = 1;
			observe(s);
			discard_mode = 1'b0;
			check(s, 2'b00);
			check(PART.frames_left, 0);
			$display("t_discard done");
		end
	endtask

	task t_halt;
		begin
			acquire_enable = 1'b0;
			repeat (300) @(negedge clock);
			check(~controller_select_n, 64'h0);
			acquire_enable = 1'b1;
			$display("t_halt done");
		end
	endtask

	initial begin
		rst_n = 1'b0;
		acquire_enable = 1'b1;
		discard_mode = 1'b0;
		frame_ready = 8'h00;
		repeat (11) @(negedge clock);
		check(~controller_select_n, 64'h0);
		check({column_clock_out, frame_valid}, 16'h0000);
		@(negedge clock);
		rst_n = 1'b1;
		t_scan;
		t_frames;
		t_bad;
		t_discard;
		t_halt;
		check(far_seen, 1'b1);
		test_done;
	end

	initial begin
		#(20 * 30000);
		err_total = err_total + 1;
		test_done;
	end
endmodule
